// *** dsa_pkg.sv ***
// package: constants and types of the data space access block
package dsa_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int EA_W = 16;
  localparam int DATA_W = 16;
  localparam int NEAR_FIELD_W = 13;
  localparam int WREG_COUNT = 16;
  localparam int WREG_IDX_W = 4;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] NEAR_FIRST = 16'h0000;
  localparam logic [15:0] NEAR_LAST = 16'h1fff;
  localparam logic [15:0] SFR_FIRST = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h07ff;
  localparam logic [15:0] WREG_FIRST = 16'h0000;
  localparam logic [15:0] WREG_LAST = 16'h001f;
  localparam logic [15:0] RAM_FIRST = 16'h0800;
  localparam logic [15:0] RAM_LAST = 16'h47ff;
  localparam int RAM_BYTES = 16384;
  localparam int RAM_WORDS = 8192;
  localparam int RAM_AW = 13;
  localparam int SFR_REGION_LSB = 5;
  localparam int SFR_REGION_MSB = 10;

  // one bit per 32-byte region of the sfr space, bit n = region n
  localparam logic [63:0] SFR_REGION_MAP = {
    8'h0c, 8'h37, 8'h00, 8'h30, 8'h03, 8'hff, 8'hff, 8'h7f
  };

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  localparam logic [15:0] WORK_REG_0_OFS = 16'h0000;
  localparam logic [15:0] WORK_REG_2_OFS = 16'h0004;
  localparam logic [15:0] WORK_REG_5_OFS = 16'h000a;
  localparam logic [15:0] WORK_REG_6_OFS = 16'h000c;
  localparam logic [15:0] WORK_REG_7_OFS = 16'h000e;
  localparam logic [15:0] WORK_REG_8_OFS = 16'h0010;
  localparam logic [15:0] WORK_REG_RESET = 16'h0000;
  localparam logic [15:0] WORK_REG_15_RESET = 16'h0800;
  localparam int WORK_REG_15_IDX = 15;

  // ----------------------------------------------------------------
  // pointer steps and lanes
  // ----------------------------------------------------------------
  localparam logic [15:0] INC_BYTE = 16'h0001;
  localparam logic [15:0] INC_WORD = 16'h0002;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  localparam logic [1:0] LANE_NONE = 2'h0;

  typedef enum logic [1:0] {
    AM_INDIRECT,
    AM_NEAR_DIRECT,
    AM_FULL_DIRECT,
    AM_SPARE
  } dsa_mode_type;

endpackage

// *** dsa_mem_if.sv ***
// interface: word port between the access logic and the data ram
`timescale 1ns/1ps
`default_nettype none

interface dsa_mem_if;
  logic [12:0] word_addr;
  logic [15:0] wdata;
  logic [1:0] wstrb;
  logic [15:0] rdata;

  modport ctrl
  (
    output word_addr,
    output wdata,
    output wstrb,
    input rdata
  );

  modport ram
  (
    input word_addr,
    input wdata,
    input wstrb,
    output rdata
  );
endinterface

`default_nettype wire

// *** dsa_data_ram.sv ***
// module: data ram as two byte-wide arrays with one word decode
`timescale 1ns/1ps
`default_nettype none

module dsa_data_ram
(
  input wire logic clock_i,
  dsa_mem_if.ram mem
);

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  // no reset on the arrays: contents are undefined until written
  logic [7:0] low_lane [dsa_pkg::RAM_WORDS];
  logic [7:0] high_lane [dsa_pkg::RAM_WORDS];

  always_ff @(posedge clock_i)
  begin
    if (mem.wstrb[0])
    begin
      low_lane[mem.word_addr] <= mem.wdata[7:0];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (mem.wstrb[1])
    begin
      high_lane[mem.word_addr] <= mem.wdata[15:8];
    end
  end

  // low byte is the even address, high byte the odd one
  assign mem.rdata = {high_lane[mem.word_addr], low_lane[mem.word_addr]};

endmodule

`default_nettype wire

// *** dsa_access.sv ***
// module: data space byte and word access logic of the core
`timescale 1ns/1ps
`default_nettype none

module dsa_access
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_byte_i,
  input wire logic [1:0] req_mode_i,
  input wire logic req_transfer_i,
  input wire logic [15:0] req_field_i,
  input wire logic [3:0] req_ptr_i,
  input wire logic req_postinc_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic req_load_i,
  input wire logic [3:0] req_dst_i,
  input wire logic ext_valid_i,
  input wire logic ext_sign_i,
  input wire logic [3:0] ext_reg_i,
  input wire logic [15:0] sfr_rdata_i,
  output logic sfr_rd_o,
  output logic [15:0] sfr_addr_o,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic [15:0] ea_o,
  output logic trap_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_byte
  (
    input logic [15:0] word,
    input logic odd
  );
    pick_byte = odd ? word[15:8] : word[7:0];
  endfunction

  function automatic logic [1:0] lane_strobes
  (
    input logic is_byte,
    input logic odd
  );
    lane_strobes = !is_byte ? dsa_pkg::LANE_BOTH :
      (odd ? dsa_pkg::LANE_HIGH : dsa_pkg::LANE_LOW);
  endfunction

  function automatic logic [15:0] merge_lanes
  (
    input logic [15:0] old_word,
    input logic [15:0] new_word,
    input logic [1:0] strb
  );
    merge_lanes[7:0] = strb[0] ? new_word[7:0] : old_word[7:0];
    merge_lanes[15:8] = strb[1] ? new_word[15:8] : old_word[15:8];
  endfunction

  // ----------------------------------------------------------------
  // state and wires
  // ----------------------------------------------------------------
  logic [15:0] wreg_r [dsa_pkg::WREG_COUNT];
  logic [15:0] wreg_nxt [dsa_pkg::WREG_COUNT];
  logic ack_r;
  logic [15:0] rdata_r;
  logic [15:0] ea_r;
  logic trap_r;

  dsa_pkg::dsa_mode_type mode;
  logic [15:0] effective_address;
  logic [15:0] ptr_val;
  logic [15:0] ptr_step;
  logic misalign;
  logic in_wreg;
  logic in_sfr;
  logic in_ram;
  logic region_impl;
  logic [5:0] region_idx;
  logic [15:0] ram_off;
  logic [1:0] strb;
  logic write_ok;
  logic [15:0] wdata_steered;
  logic [15:0] rd_word;
  logic [15:0] rd_data;

  dsa_mem_if mem_bus ();

  dsa_data_ram u_ram
  (
    .clock_i(clock_i),
    .mem(mem_bus)
  );

  // ----------------------------------------------------------------
  // effective address generation
  // ----------------------------------------------------------------
  assign mode = dsa_pkg::dsa_mode_type'(req_mode_i);
  assign ptr_val = wreg_r[req_ptr_i];

  always_comb
  begin
    case (mode)
      dsa_pkg::AM_INDIRECT:
      begin
        effective_address = ptr_val;
      end
      dsa_pkg::AM_NEAR_DIRECT:
      begin
        effective_address = {3'h0, req_field_i[12:0]};
      end
      dsa_pkg::AM_FULL_DIRECT:
      begin
        // a full field is honoured only for transfer instructions
        if (req_transfer_i)
        begin
          effective_address = req_field_i;
        end
        else
        begin
          effective_address = {3'h0, req_field_i[12:0]};
        end
      end
      default:
      begin
        effective_address = ptr_val;
      end
    endcase
  end

  // pointer scaling follows the operand size
  assign ptr_step = req_byte_i ? dsa_pkg::INC_BYTE : dsa_pkg::INC_WORD;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign misalign = req_valid_i & ~req_byte_i & effective_address[0];
  assign in_wreg = effective_address <= dsa_pkg::WREG_LAST;
  assign in_sfr = effective_address <= dsa_pkg::SFR_LAST;
  assign in_ram = (effective_address >= dsa_pkg::RAM_FIRST) &&
    (effective_address <= dsa_pkg::RAM_LAST);
  assign region_idx = effective_address[dsa_pkg::SFR_REGION_MSB:
    dsa_pkg::SFR_REGION_LSB];
  assign region_impl = dsa_pkg::SFR_REGION_MAP[region_idx];
  assign ram_off = effective_address - dsa_pkg::RAM_FIRST;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  assign strb = lane_strobes(req_byte_i, effective_address[0]);
  // misaligned writes still retire, only the strobes are withheld
  assign write_ok = req_valid_i & req_write_i & ~misalign & clk_en_i;
  assign wdata_steered = req_byte_i ?
    {req_wdata_i[7:0], req_wdata_i[7:0]} : req_wdata_i;

  assign mem_bus.word_addr = ram_off[13:1];
  assign mem_bus.wdata = wdata_steered;
  assign mem_bus.wstrb = (write_ok & in_ram) ? strb :
    dsa_pkg::LANE_NONE;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // peripherals answer only inside implemented regions
  assign sfr_rd_o = req_valid_i & ~req_write_i & clk_en_i & in_sfr &
    ~in_wreg & region_impl;
  assign sfr_addr_o = effective_address;

  always_comb
  begin
    if (in_wreg)
    begin
      rd_word = wreg_r[effective_address[4:1]];
    end
    else if (in_sfr)
    begin
      rd_word = region_impl ? sfr_rdata_i : 16'h0000;
    end
    else if (in_ram)
    begin
      rd_word = mem_bus.rdata;
    end
    else
    begin
      rd_word = 16'h0000;
    end
  end

  // whole word fetched; bit 0 is ignored for a misaligned word read of ram or a working register
  assign rd_data = req_byte_i ?
    {8'h00, pick_byte(rd_word, effective_address[0])} : rd_word;

  // ----------------------------------------------------------------
  // working register update
  // ----------------------------------------------------------------
  // later sources win: mapped write, pointer step, load, extend
  always_comb
  begin
    for (int i = 0; i < dsa_pkg::WREG_COUNT; i++)
    begin
      wreg_nxt[i] = wreg_r[i];
      if (write_ok && in_wreg && effective_address[4:1] == 4'(i))
      begin
        wreg_nxt[i] = merge_lanes(wreg_r[i], wdata_steered, strb);
      end
      if (req_valid_i && mode == dsa_pkg::AM_INDIRECT && req_postinc_i &&
        req_ptr_i == 4'(i))
      begin
        wreg_nxt[i] = ptr_val + ptr_step;
      end
      if (req_valid_i && !req_write_i && req_load_i && req_dst_i == 4'(i))
      begin
        if (req_byte_i)
        begin
          wreg_nxt[i] = {wreg_r[i][15:8], rd_data[7:0]};
        end
        else
        begin
          wreg_nxt[i] = rd_data;
        end
      end
      if (ext_valid_i && ext_reg_i == 4'(i))
      begin
        if (ext_sign_i)
        begin
          wreg_nxt[i] = {{8{wreg_r[i][7]}}, wreg_r[i][7:0]};
        end
        else
        begin
          wreg_nxt[i] = {8'h00, wreg_r[i][7:0]};
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < dsa_pkg::WREG_COUNT; i++)
      begin
        wreg_r[i] <= (i == dsa_pkg::WORK_REG_15_IDX) ?
          dsa_pkg::WORK_REG_15_RESET : dsa_pkg::WORK_REG_RESET;
      end
    end
    else if (clk_en_i)
    begin
      for (int i = 0; i < dsa_pkg::WREG_COUNT; i++)
      begin
        wreg_r[i] <= wreg_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // answer to the requester
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ack_r <= req_valid_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= 16'h0000;
    end
    else if (clk_en_i && req_valid_i && !req_write_i)
    begin
      rdata_r <= rd_data;
    end
  end

  // the address of every request taken with the enable high is kept for the trap handler to inspect
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ea_r <= 16'h0000;
    end
    else if (clk_en_i && req_valid_i)
    begin
      ea_r <= effective_address;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      trap_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      trap_r <= misalign;
    end
  end

  assign ack_o = ack_r;
  assign rdata_o = rdata_r;
  assign ea_o = ea_r;
  assign trap_o = trap_r;

endmodule

`default_nettype wire

// *** dsa_sfr_model.sv ***
// sfr peripheral model answering reads of the access block
`timescale 1ns/1ps
`default_nettype none

module dsa_sfr_model
(
  input wire logic clock_i,
  input wire logic sfr_rd_i,
  input wire logic [15:0] sfr_addr_i,
  output logic [15:0] sfr_rdata_o
);
  logic [15:0] churn_r = 16'h0000;

  always_ff @(posedge clock_i)
  begin
    churn_r <= churn_r + 16'h3b1d;
  end

  // idle bus churns so a stale value never passes for read data
  assign sfr_rdata_o = sfr_rd_i ? (sfr_addr_i ^ 16'h5aa5) : churn_r;
endmodule

`default_nettype wire

// *** dsa_access_assertions.sv ***
// checker: concurrent properties on the access block ports
`timescale 1ns/1ps
`default_nettype none

module dsa_access_assertions
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_byte_i,
  input wire logic [1:0] req_mode_i,
  input wire logic req_transfer_i,
  input wire logic [15:0] req_field_i,
  input wire logic sfr_rd_o,
  input wire logic [15:0] sfr_addr_o,
  input wire logic ack_o,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] ea_o,
  input wire logic trap_o
);
  logic acc;
  logic odd_word;

  assign acc = clk_en_i && req_valid_i;
  assign odd_word = acc && !req_byte_i && sfr_addr_o[0];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_follows: assert property (acc |=> ack_o)
    else $error("no ack after request");
  a_ack_quiet: assert property (clk_en_i && !acc |=> !ack_o)
    else $error("ack without request");
  a_trap_odd: assert property (odd_word |=> trap_o)
    else $error("odd word access without trap");
  a_trap_only: assert property (clk_en_i && !odd_word |=> !trap_o)
    else $error("trap without odd word access");
  a_ea_capture: assert property (acc |=> ea_o == $past(sfr_addr_o))
    else $error("address not captured");
  a_near_field: assert property (acc && req_mode_i == 2'h1 |->
    sfr_addr_o == {3'h0, req_field_i[12:0]})
    else $error("near field address wrong");
  a_full_field: assert property (acc && req_mode_i == 2'h2 |->
    sfr_addr_o == (req_transfer_i ? req_field_i :
    {3'h0, req_field_i[12:0]}))
    else $error("direct field address wrong");
  a_byte_high: assert property (acc && !req_write_i && req_byte_i |=>
    rdata_o[15:8] == 8'h00)
    else $error("byte read high half not zero");
  a_sfr_window: assert property (sfr_rd_o |->
    sfr_addr_o >= 16'h0020 && sfr_addr_o <= 16'h07ff)
    else $error("sfr read outside sfr region");
  a_rdata_hold: assert property (acc && req_write_i |=> $stable(rdata_o))
    else $error("read data moved on a write");
  a_outside_zero: assert property (acc && !req_write_i &&
    sfr_addr_o >= 16'h4800 |=> rdata_o == 16'h0000)
    else $error("outside read not zero");
  // a low enable must freeze every registered answer
  a_freeze_hold: assert property (!clk_en_i |=> $stable(ack_o) &&
    $stable(trap_o) && $stable(rdata_o) && $stable(ea_o))
    else $error("state moved while clock enable low");

  c_odd_write: cover property (odd_word && req_write_i);
  c_sfr_read: cover property (sfr_rd_o);
  c_byte_read: cover property (acc && req_byte_i && !req_write_i);
  c_freeze: cover property (!clk_en_i && req_valid_i);
endmodule

`default_nettype wire

// *** tb_top.sv ***
// testbench: byte and word accesses through the core access port
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end

module tb_top;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic req_valid_i = 1'b0, req_write_i = 1'b0, req_byte_i = 1'b0;
  logic [1:0] req_mode_i = 2'h0;
  logic req_transfer_i = 1'b0, req_postinc_i = 1'b0, req_load_i = 1'b0;
  logic [15:0] req_field_i = 16'h0000, req_wdata_i = 16'h0000;
  logic [3:0] req_ptr_i = 4'h0, req_dst_i = 4'h0, ext_reg_i = 4'h0;
  logic ext_valid_i = 1'b0, ext_sign_i = 1'b0;
  logic [15:0] sfr_rdata_i, sfr_addr_o, rdata_o, ea_o;
  logic sfr_rd_o, ack_o, trap_o;
  logic tr, pi, ld;
  logic [3:0] ptr, dst;
  int bad_count = 0;
  int checked = 0;

  always #12.5 clock_i = ~clock_i;

  dsa_access dsa_access_i (.clock_i, .rstn_i, .clk_en_i, .req_valid_i,
    .req_write_i, .req_byte_i, .req_mode_i, .req_transfer_i, .req_field_i,
    .req_ptr_i, .req_postinc_i, .req_wdata_i, .req_load_i, .req_dst_i,
    .ext_valid_i, .ext_sign_i, .ext_reg_i, .sfr_rdata_i, .sfr_rd_o,
    .sfr_addr_o, .ack_o, .rdata_o, .ea_o, .trap_o);

  dsa_sfr_model dsa_sfr_model_i (.clock_i, .sfr_rd_i(sfr_rd_o),
    .sfr_addr_i(sfr_addr_o), .sfr_rdata_o(sfr_rdata_i));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // one idle cycle between requests keeps every check in its own cycle
  task automatic go(input logic w, input logic b, input logic [1:0] m,
    input logic [15:0] f, input logic [15:0] d);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_byte_i <= b;
    req_mode_i <= m;
    req_field_i <= f;
    req_wdata_i <= d;
    req_transfer_i <= tr;
    req_postinc_i <= pi;
    req_load_i <= ld;
    req_ptr_i <= ptr;
    req_dst_i <= dst;
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic b);
    go(1'b0, b, 2'h2, a, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
    go(1'b1, b, 2'h2, a, d);
  endtask

  task automatic ext(input logic s, input logic [3:0] r);
    @(posedge clock_i);
    ext_valid_i <= 1'b1;
    ext_sign_i <= s;
    ext_reg_i <= r;
    @(posedge clock_i);
    ext_valid_i <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    tr = 1'b1;
    pi = 1'b0;
    ld = 1'b0;
    ptr = 4'h0;
    dst = 4'h0;
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      rd(16'(2 * i), 1'b0);
      `CHK("wreg", (i == 15) ? 16'h0800 : 16'h0000, rdata_o)
    end
    done("reset");
    wr(16'h0800, 1'b0, 16'h1234);
    rd(16'h0800, 1'b1);
    `CHK("lo", 16'h0034, rdata_o)
    rd(16'h0801, 1'b1);
    `CHK("hi", 16'h0012, rdata_o)
    wr(16'h0801, 1'b1, 16'h77ab);
    rd(16'h0800, 1'b0);
    `CHK("lane", 16'hab34, rdata_o)
    done("lanes");
    wr(16'h0802, 1'b0, 16'h5a5a);
    wr(16'h0803, 1'b0, 16'hffff);
    `CHK("wtrap", 1'b1, trap_o)
    rd(16'h0802, 1'b0);
    `CHK("nowr", 16'h5a5a, rdata_o)
    rd(16'h0803, 1'b0);
    `CHK("rtrap", 1'b1, trap_o)
    `CHK("rdone", 16'h5a5a, rdata_o)
    `CHK("ea", 16'h0803, ea_o)
    `CHK("ack", 1'b1, ack_o)
    done("misalign");
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    wr(16'h0802, 1'b0, 16'h1111);
    `CHK("frz_ack", 1'b0, ack_o)
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    rd(16'h0802, 1'b0);
    `CHK("frozen", 16'h5a5a, rdata_o)
    done("freeze");
    wr(16'h0004, 1'b0, 16'h0800);
    ptr = 4'h2;
    pi = 1'b1;
    go(1'b0, 1'b0, 2'h0, 16'h0000, 16'h0000);
    `CHK("ind", 16'hab34, rdata_o)
    go(1'b0, 1'b1, 2'h0, 16'h0000, 16'h0000);
    `CHK("indb", 16'h005a, rdata_o)
    pi = 1'b0;
    rd(16'h0004, 1'b0);
    `CHK("ptr", 16'h0803, rdata_o)
    go(1'b0, 1'b1, 2'h3, 16'h0000, 16'h0000);
    `CHK("spare", 16'h005a, rdata_o)
    done("postinc");
    wr(16'h000a, 1'b0, 16'hbeef);
    ld = 1'b1;
    dst = 4'h5;
    rd(16'h0801, 1'b1);
    ld = 1'b0;
    rd(16'h000a, 1'b0);
    `CHK("load", 16'hbeab, rdata_o)
    ext(1'b1, 4'h5);
    rd(16'h000a, 1'b0);
    `CHK("sext", 16'hffab, rdata_o)
    ext(1'b0, 4'h5);
    rd(16'h000a, 1'b0);
    `CHK("zext", 16'h00ab, rdata_o)
    done("extend");
    go(1'b0, 1'b0, 2'h1, 16'he800, 16'h0000);
    `CHK("near", 16'hab34, rdata_o)
    tr = 1'b0;
    go(1'b0, 1'b0, 2'h2, 16'he800, 16'h0000);
    `CHK("mask", 16'hab34, rdata_o)
    tr = 1'b1;
    rd(16'h5000, 1'b0);
    `CHK("out", 16'h0000, rdata_o)
    rd(16'h0020, 1'b0);
    `CHK("sfr", 16'h5a85, rdata_o)
    rd(16'h00e0, 1'b0);
    `CHK("gap", 16'h0000, rdata_o)
    done("map");
    wrap_up();
  end

  initial
  begin
    #50000;
    bad_count++;
    wrap_up();
  end
endmodule

bind dsa_access dsa_access_assertions dsa_access_assertions_i (.clock_i,
  .rstn_i, .clk_en_i, .req_valid_i, .req_write_i, .req_byte_i, .req_mode_i,
  .req_transfer_i, .req_field_i, .sfr_rd_o, .sfr_addr_o, .ack_o, .rdata_o,
  .ea_o, .trap_o);

`default_nettype wire
